/* dv/fcd_exec_properties.sv */
module fcd_exec_properties (
  input wire       clk,
  input wire       nrst,
  input wire       file_we,
  input wire [7:0] w_reg,
  input wire       zero_flag,
  input wire [1:0] phase,
  input wire       skipping
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_PHASE: assert property (phase != 2'h0 |-> phase == $past(phase) + 2'h1)
    else $error("phase");
  AST_WE: assert property (file_we |-> phase == 2'h0) else $error("we");
  AST_IDLE: assert property (skipping |-> !file_we) else $error("idle");
  AST_HOLD: assert property (skipping |-> $stable({w_reg, zero_flag})) else $error("h");
  AST_WQ4: assert property (phase != 2'h0 |-> $stable(w_reg)) else $error("w");
  AST_ZQ4: assert property (phase != 2'h0 |-> $stable(zero_flag)) else $error("z");
  AST_SKIP: assert property ($rose(skipping) |-> skipping[*4] ##1 !skipping)
    else $error("skip");
endmodule // fcd_exec_properties
bind fcd_exec fcd_exec_properties u_props (
  .clk       (clk),
  .nrst      (nrst),
  .file_we   (file_we),
  .w_reg     (w_reg),
  .zero_flag (zero_flag),
  .phase     (phase),
  .skipping  (skipping)
);

/* dv/fcd_exec_tb.sv */
module fcd_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, nrst = 0, file_rd, file_we, zero_flag, skipping, xz = 0, sn = 0, p;
  logic [13:0] instr = 0;
  logic [9:0]  a;
  logic [7:0]  file_rdata = 0, file_wdata, w_reg, xw = 0, r, s;
  logic [6:0]  file_addr;
  logic [1:0]  phase;
  logic [17:0] q[$], m;
  logic [7:0]  qr[$], mr;
  int          seed = 93603, num_errors = 0, checked = 0, cyc = 0;
  fcd_exec uut (
    .clk        (clk),
    .nrst       (nrst),
    .instr      (instr),
    .file_rdata (file_rdata),
    .file_addr  (file_addr),
    .file_rd    (file_rd),
    .file_wdata (file_wdata),
    .file_we    (file_we),
    .w_reg      (w_reg),
    .zero_flag  (zero_flag),
    .phase      (phase),
    .skipping   (skipping)
  );
  initial forever #50 clk = ~clk;
  task automatic cmp(input string n, input logic [8:0] x, y);
    checked++;
    num_errors += x !== y;
    if (x !== y) $display("mismatch %s %h %h", n, x, y);
  endtask
  task automatic close_out;
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    nrst <= cyc > 5;
    cyc <= cyc + 1;
    if (nrst && phase == 2'h3) begin
      a = 10'($random(seed));
      r = a[2] ? 8'h01 : a[7:0];
      s = a[9:8] == 2'h0 ? ~r : r - 8'h01;
      p = !sn && a[9:8] != 2'h3;
      if (p && !a[7]) xw = s;
      if (p && !a[9]) xz = s == 8'h00;
      q.push_back({p && a[7], s & {8{p && a[7]}}, xw, xz});
      qr.push_back({p, a[6:0]});
      sn = p && a[9:8] == 2'h2 && s == 8'h00;
      instr <= {a[9] ? (a[8] ? 6'h2A : 6'h0B) : (a[8] ? 6'h03 : 6'h09), a[7:0]};
      file_rdata <= r;
    end
    if (cyc == 1500) begin
      num_errors++;
      close_out;
    end
  end
  always @(negedge clk) begin
    if (phase == 2'h1 && qr.size() > 0) begin
      mr = qr.pop_front();
      cmp("rd_addr", {1'b0, mr}, {1'b0, file_rd, file_addr});
    end
    if (phase == 2'h0 && q.size() > 1) begin
      m = q.pop_front();
      cmp("w_z", m[8:0], {w_reg, zero_flag});
      cmp("file", m[17:9], {file_we, file_wdata & {8{file_we}}});
    end
    if (checked > 500) close_out;
  end
endmodule // fcd_exec_tb

/* pkg/fcd_regs.vh */
`ifndef FCD_REGS_VH
`define FCD_REGS_VH
// Opcode fields of the 14-bit instruction word
`define FCD_OPC_HI        13
`define FCD_OPC_LO        8
`define FCD_DEST_BIT      7
`define FCD_ADDR_HI       6
`define FCD_ADDR_LO       0
`define FCD_OPC_COMPL     6'h09
`define FCD_OPC_DECR      6'h03
`define FCD_OPC_DECR_SKIP 6'h0B
// Instruction-cycle phases
`define FCD_Q1            2'h0
`define FCD_Q2            2'h1
`define FCD_Q3            2'h2
`define FCD_Q4            2'h3
// Operation codes after decode
`define FCD_OP_IDLE       2'h0
`define FCD_OP_COMP       2'h1
`define FCD_OP_DEC        2'h2
`define FCD_OP_DECSKIP    2'h3
// Reset values
`define FCD_W_RST         8'h00
`define FCD_ZERO_RST      1'h0
`endif

/* src/fcd_decode.v */
`include "fcd_regs.vh"

module fcd_decode (
  input  wire [13:0] instr,     // Instruction word
  output reg  [1:0]  op,        // Decoded operation
  output wire        dest,      // 1 = file register, 0 = accumulator
  output wire [6:0]  addr       // File register address
);
  wire [5:0] opc;
  assign opc  = instr[`FCD_OPC_HI:`FCD_OPC_LO];
  assign dest = instr[`FCD_DEST_BIT];
  assign addr = instr[`FCD_ADDR_HI:`FCD_ADDR_LO];

  always @* begin
    case (opc)
      `FCD_OPC_COMPL:     op = `FCD_OP_COMP;
      `FCD_OPC_DECR:      op = `FCD_OP_DEC;
      `FCD_OPC_DECR_SKIP: op = `FCD_OP_DECSKIP;
      default:         op = `FCD_OP_IDLE;
    endcase
  end
endmodule // fcd_decode

/* src/fcd_exec.v */
`include "fcd_regs.vh"

// Function
// - Complement file register, route by destination, Z
// - Decrement file register, route by destination, Z
// - Skip-decrement routes same, flags untouched
// - Zero skip-decrement result idles next instruction
// - Four phases: decode, read, compute, write
// - Skipped cycle reads, computes and writes nothing; Q1 still loads file_addr and dest
module fcd_exec (
  input  wire        clk,        // 10 MHz phase clock
  input  wire        nrst,       // Synchronous reset, active low
  input  wire [13:0] instr,      // Fetched instruction, held for the cycle
  input  wire [7:0]  file_rdata, // Addressed file register data
  output reg  [6:0]  file_addr,  // File register address
  output wire        file_rd,    // File read strobe in Q2
  output reg  [7:0]  file_wdata, // File write data
  output reg         file_we,    // File write strobe, set at the end of Q4 and high in Q1
  output reg  [7:0]  w_reg,      // Accumulator
  output reg         zero_flag,  // Zero status flag
  output reg  [1:0]  phase,      // Current phase
  output reg         skipping    // Current cycle is a slot skipped after a zero skip-decrement
);
  wire [1:0] dec_op;
  wire       dec_dest;
  wire [6:0] dec_addr;
  reg  [1:0] op;
  reg        dest;
  reg  [7:0] operand;
  reg  [7:0] result;
  reg        skip_pend;

  fcd_decode u_dec (
    .instr (instr),
    .op    (dec_op),
    .dest  (dec_dest),
    .addr  (dec_addr)
  );

  // Read only when a real operation is latched
  assign file_rd = (phase == `FCD_Q2) && (op != `FCD_OP_IDLE);

  always @(posedge clk) begin
    if (!nrst) begin
      phase      <= `FCD_Q1;
      op         <= `FCD_OP_IDLE;
      dest       <= 1'b0;
      file_addr  <= 7'h00;
      operand    <= 8'h00;
      result     <= 8'h00;
      file_wdata <= 8'h00;
      file_we    <= 1'b0;
      w_reg      <= `FCD_W_RST;
      zero_flag  <= `FCD_ZERO_RST;
      skipping   <= 1'b0;
      skip_pend  <= 1'b0;
    end else begin
      phase   <= phase + 2'h1;
      file_we <= 1'b0;
      case (phase)
        `FCD_Q1: begin
          // Skipped slot forces idle whatever was fetched
          if (skip_pend) begin
            op       <= `FCD_OP_IDLE;
            skipping <= 1'b1;
          end else begin
            op       <= dec_op;
            skipping <= 1'b0;
          end
          skip_pend <= 1'b0;
          dest      <= dec_dest;
          file_addr <= dec_addr;
        end
        `FCD_Q2: begin
          if (op != `FCD_OP_IDLE)
            operand <= file_rdata;
        end
        `FCD_Q3: begin
          case (op)
            `FCD_OP_COMP:    result <= ~operand;
            `FCD_OP_DEC:     result <= operand - 8'h01;
            `FCD_OP_DECSKIP: result <= operand - 8'h01;
            default:         result <= result;
          endcase
        end
        `FCD_Q4: begin
          if (op != `FCD_OP_IDLE) begin
            if (dest) begin
              file_wdata <= result;
              file_we    <= 1'b1;
            end else begin
              w_reg <= result;
            end
            // Skip variant leaves status alone
            if (op != `FCD_OP_DECSKIP)
              zero_flag <= (result == 8'h00);
            else
              skip_pend <= (result == 8'h00);
          end
        end
        default: begin
          op <= `FCD_OP_IDLE;
        end
      endcase
    end
  end
endmodule // fcd_exec
